// *** include/pfs_regs.vh ***
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
// widths
`define PFS_PC_W        23
`define PFS_PMEM_W      24
`define PFS_PC_STEP     23'h000002
`define PFS_PC_STEP2    23'h000004
`define PFS_PC_RESET    23'h000000
// flow commands
`define PFS_CMD_W       4
`define PFS_CMD_SEQ     4'h0
`define PFS_CMD_BRA     4'h1
`define PFS_CMD_BRA_C   4'h2
`define PFS_CMD_CALL    4'h3
`define PFS_CMD_CALL_W  4'h4
`define PFS_CMD_GOTO    4'h5
`define PFS_CMD_GOTO_W  4'h6
`define PFS_CMD_RELATIVE_CALL   4'h7
`define PFS_CMD_RELATIVE_CALL_W 4'h8
`define PFS_CMD_RETURN  4'h9
`define PFS_CMD_RETURN_WITH_LITERAL   4'hA
`define PFS_CMD_RETURN_FROM_INTERRUPT  4'hB
`define PFS_CMD_EXC     4'hC
// immediate kinds
`define PFS_IMM_W       4
`define PFS_IMM_LIT1    4'h0
`define PFS_IMM_BIT4    4'h1
`define PFS_IMM_LIT4    4'h2
`define PFS_IMM_SIGNED_IMM4   4'h3
`define PFS_IMM_LIT5    4'h4
`define PFS_IMM_SIGNED_IMM6   4'h5
`define PFS_IMM_LIT8    4'h6
`define PFS_IMM_LIT10   4'h7
`define PFS_IMM_SIGNED_IMM10  4'h8
`define PFS_IMM_UNSIGNED_IMM14   4'h9
`define PFS_IMM_LIT16   4'hA
// field positions in the instruction word
`define PFS_IMM_LSB     4
// address modes
`define PFS_AM_NONE     2'h0
`define PFS_AM_DIRECT   2'h1
`define PFS_AM_IND      2'h2
`define PFS_AM_INDMOD   2'h3
`define PFS_SP_REG      4'hF
`endif

// *** design/pfs_imm_extract.v ***
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_imm_extract (
	// instruction and kind
	input  wire [23:0] instr_word,
	input  wire [3:0]  imm_kind,
	// result
	output reg  [15:0] imm_value
);
	wire [15:0] f;
	assign f = instr_word[`PFS_IMM_LSB +: 16];
	always @* begin
		case (imm_kind)
			`PFS_IMM_LIT1:   imm_value = {15'h0000, f[0]};
			`PFS_IMM_BIT4:   imm_value = {12'h000, f[3:0]};
			`PFS_IMM_LIT4:   imm_value = {12'h000, f[3:0]};
			`PFS_IMM_SIGNED_IMM4:  imm_value = {{12{f[3]}}, f[3:0]};
			`PFS_IMM_LIT5:   imm_value = {11'h000, f[4:0]};
			`PFS_IMM_SIGNED_IMM6:  imm_value = {{10{f[5]}}, f[5:0]};
			`PFS_IMM_LIT8:   imm_value = {8'h00, f[7:0]};
			`PFS_IMM_LIT10:  imm_value = {6'h00, f[9:0]};
			`PFS_IMM_SIGNED_IMM10: imm_value = {{6{f[9]}}, f[9:0]};
			`PFS_IMM_UNSIGNED_IMM14:  imm_value = {2'h0, f[13:0]};
			`PFS_IMM_LIT16:  imm_value = f;
			default:         imm_value = 16'h0000;
		endcase
	end
endmodule

// *** design/pfs_hazard_detect.v ***
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_hazard_detect (
	// executing instruction
	input  wire [3:0] ex_dst_reg,
	input  wire [1:0] ex_dst_mode,
	input  wire       ex_is_call,
	// prefetched instruction
	input  wire [3:0] pf_src_reg,
	input  wire [1:0] pf_src_mode,
	// result
	output wire       raw_hazard
);
	wire src_ind;
	wire dst_write;
	wire match;
	// only an indirect source read depends on the pointer value
	assign src_ind   = (pf_src_mode == `PFS_AM_IND) || (pf_src_mode == `PFS_AM_INDMOD);
	// direct and indirect destinations may both change the register
	assign dst_write = (ex_dst_mode != `PFS_AM_NONE);
	// the plain indirect-to-indirect case stalls: the write target may map onto the pointer
	assign match     = dst_write && (ex_dst_reg == pf_src_reg);
	assign raw_hazard = src_ind && (match ||
	                    (ex_is_call && pf_src_reg == `PFS_SP_REG));
endmodule

// *** design/pfs_flow_seq.v ***
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_flow_seq #(
	parameter PC_W = `PFS_PC_W
) (
	// clock and reset
	input  wire            clk,
	input  wire            reset,
	// instruction issue
	input  wire            instr_valid,
	input  wire [3:0]      flow_cmd,
	input  wire            cond_true,
	input  wire [23:0]     instr_word,
	input  wire [22:0]     absolute_target23,
	input  wire [15:0]     signed_disp16,
	input  wire [15:0]     working_reg_n,
	input  wire [22:0]     vector_addr,
	input  wire [3:0]      imm_kind,
	// hazard operands
	input  wire [3:0]      ex_dst_reg,
	input  wire [1:0]      ex_dst_mode,
	input  wire [3:0]      pf_src_reg,
	input  wire [1:0]      pf_src_mode,
	// hardware loops
	input  wire            do_active,
	input  wire [22:0]     loop_start_address,
	input  wire [22:0]     loop_end_address,
	input  wire            repeat_active,
	// stack memory
	input  wire [15:0]     stack_pointer_reg,
	input  wire [15:0]     stack_rd_data,
	// program memory side
	output reg  [PC_W-1:0] prog_addr,
	output reg             stall,
	output reg             busy,
	output reg  [15:0]     imm_out,
	// stack access
	output reg             stack_wr,
	output reg             stack_rd,
	output reg  [15:0]     stack_addr,
	output reg  [15:0]     stack_wr_data,
	output reg  [15:0]     stack_ptr_new,
	output reg             stack_ptr_upd
);
	// a pop needs a third state: the model answers a read one edge after it is asked
	localparam [5:0] ST_RUN  = 6'h01;
	localparam [5:0] ST_PSH1 = 6'h02;
	localparam [5:0] ST_PSH2 = 6'h04;
	localparam [5:0] ST_POP1 = 6'h08;
	localparam [5:0] ST_POP2 = 6'h10;
	localparam [5:0] ST_POP3 = 6'h20;

	reg  [5:0]      state_q;
	reg  [5:0]      state_d;
	reg  [PC_W-1:0] pc_q;
	reg  [PC_W-1:0] pc_d;
	reg  [PC_W-1:0] ret_q;
	reg  [PC_W-1:0] ret_d;
	reg  [PC_W-1:0] tgt_q;
	reg  [PC_W-1:0] tgt_d;
	reg  [15:0]     sp_q;
	reg  [15:0]     sp_d;
	reg  [15:0]     pop_lo_q;
	reg  [15:0]     pop_lo_d;
	reg             push_d;
	reg             pop_d;
	reg             was_call_q;
	reg             stall_q;
	wire            raw_hazard;
	wire [15:0]     imm_value;
	wire [PC_W-1:0] pc_seq;
	wire [PC_W-1:0] pc_rel;
	wire [PC_W-1:0] pc_relw;
	wire [PC_W-1:0] wreg_ext;
	wire            stall_now;

	pfs_imm_extract u_imm (
		.instr_word (instr_word),
		.imm_kind   (imm_kind),
		.imm_value  (imm_value)
	);

	pfs_hazard_detect u_haz (
		.ex_dst_reg  (ex_dst_reg),
		.ex_dst_mode (ex_dst_mode),
		.ex_is_call  (was_call_q),
		.pf_src_reg  (pf_src_reg),
		.pf_src_mode (pf_src_mode),
		.raw_hazard  (raw_hazard)
	);

	assign pc_seq   = pc_q + `PFS_PC_STEP;
	assign pc_rel   = pc_q + {{(PC_W-17){signed_disp16[15]}}, signed_disp16, 1'b0};
	assign pc_relw  = pc_q + {{(PC_W-17){working_reg_n[15]}}, working_reg_n, 1'b0};
	assign wreg_ext = {{(PC_W-16){1'b0}}, working_reg_n};
	// a second stall right after one would starve the write, so a stall lasts one cycle
	assign stall_now = raw_hazard && instr_valid && !stall_q && state_q == ST_RUN;

	always @* begin
		state_d  = state_q;
		pc_d     = pc_q;
		ret_d    = ret_q;
		tgt_d    = tgt_q;
		sp_d     = sp_q;
		pop_lo_d = pop_lo_q;
		push_d   = 1'b0;
		pop_d    = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (instr_valid && !stall_now) begin
					case (flow_cmd)
						`PFS_CMD_BRA: pc_d = pc_rel;
						`PFS_CMD_BRA_C: pc_d = cond_true ? pc_rel : pc_seq;
						`PFS_CMD_CALL: begin
							ret_d  = pc_q + `PFS_PC_STEP2;
							tgt_d  = absolute_target23;
							push_d = 1'b1;
						end
						`PFS_CMD_CALL_W: begin
							ret_d  = pc_seq;
							tgt_d  = wreg_ext;
							push_d = 1'b1;
						end
						`PFS_CMD_GOTO: pc_d = absolute_target23;
						`PFS_CMD_GOTO_W: pc_d = wreg_ext;
						`PFS_CMD_RELATIVE_CALL: begin
							ret_d  = pc_seq;
							tgt_d  = pc_rel;
							push_d = 1'b1;
						end
						`PFS_CMD_RELATIVE_CALL_W: begin
							ret_d  = pc_seq;
							tgt_d  = pc_relw;
							push_d = 1'b1;
						end
						`PFS_CMD_RETURN, `PFS_CMD_RETURN_WITH_LITERAL, `PFS_CMD_RETURN_FROM_INTERRUPT: begin
							pop_d = 1'b1;
						end
						`PFS_CMD_EXC: begin
							ret_d  = pc_seq;
							tgt_d  = vector_addr;
							push_d = 1'b1;
						end
						default: begin
							if (repeat_active)
								pc_d = pc_q;
							else if (do_active && pc_q == loop_end_address)
								pc_d = loop_start_address;
							else
								pc_d = pc_seq;
						end
					endcase
					if (push_d)
						state_d = ST_PSH1;
					if (pop_d) begin
						state_d = ST_POP1;
						sp_d    = stack_pointer_reg - 16'h0002;
					end
					// a push starts from the live pointer, never a stale copy
					if (!pop_d)
						sp_d = stack_pointer_reg;
				end
			end
			ST_PSH1: begin
				sp_d    = sp_q + 16'h0002;
				state_d = ST_PSH2;
			end
			ST_PSH2: begin
				sp_d    = sp_q + 16'h0002;
				pc_d    = tgt_q;
				state_d = ST_RUN;
			end
			ST_POP1: begin
				sp_d    = sp_q - 16'h0002;
				state_d = ST_POP2;
			end
			ST_POP2: begin
				// first word back is the high part, read at SP-2
				pop_lo_d = stack_rd_data;
				state_d  = ST_POP3;
			end
			ST_POP3: begin
				state_d = ST_RUN;
			end
			default: state_d = ST_RUN;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			state_q       <= ST_RUN;
			pc_q          <= `PFS_PC_RESET;
			ret_q         <= `PFS_PC_RESET;
			tgt_q         <= `PFS_PC_RESET;
			sp_q          <= 16'h0000;
			pop_lo_q      <= 16'h0000;
			was_call_q    <= 1'b0;
			stall_q       <= 1'b0;
			prog_addr     <= `PFS_PC_RESET;
			stall         <= 1'b0;
			busy          <= 1'b0;
			imm_out       <= 16'h0000;
			stack_wr      <= 1'b0;
			stack_rd      <= 1'b0;
			stack_addr    <= 16'h0000;
			stack_wr_data <= 16'h0000;
			stack_ptr_new <= 16'h0000;
			stack_ptr_upd <= 1'b0;
		end else begin
			state_q    <= state_d;
			ret_q      <= ret_d;
			tgt_q      <= tgt_d;
			sp_q       <= sp_d;
			pop_lo_q   <= pop_lo_d;
			stall_q    <= stall_now;
			stall      <= stall_now;
			// a call leaves the stack pointer dirty for the instruction that follows
			if (state_q == ST_PSH2)
				was_call_q <= 1'b1;
			else if (instr_valid && state_q == ST_RUN && !stall_now)
				was_call_q <= 1'b0;
			imm_out    <= imm_value;
			busy       <= (state_d != ST_RUN);
			stack_wr   <= (state_q == ST_PSH1) || (state_q == ST_PSH2);
			// reads are issued one cycle ahead so both words are back by the last pop state
			stack_rd   <= (state_d == ST_POP1) || (state_d == ST_POP2);
			if ((state_d == ST_POP1) || (state_d == ST_POP2))
				stack_addr <= sp_d;
			else
				stack_addr <= sp_q;
			// low word first, then high bits zero-filled
			if (state_q == ST_PSH1)
				stack_wr_data <= ret_q[15:0];
			else
				stack_wr_data <= {{(32-PC_W){1'b0}}, ret_q[PC_W-1:16]};
			stack_ptr_upd <= (state_q == ST_PSH2) || (state_q == ST_POP3);
			stack_ptr_new <= sp_d;
			if (state_q == ST_PSH2)
				pc_q <= {pc_d[PC_W-1:1], 1'b0};
			else if (state_q == ST_POP3)
				pc_q <= {pop_lo_q[PC_W-17:0], stack_rd_data[15:1], 1'b0};
			else if (state_q == ST_RUN && state_d == ST_RUN && instr_valid)
				pc_q <= {pc_d[PC_W-1:1], 1'b0};
			prog_addr <= pc_q;
		end
	end
endmodule

// *** testbench/pfs_flow_assertions.sv ***
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_flow_assertions (
	// clock and reset
	input wire        clk,
	input wire        reset,
	// issue side
	input wire        instr_valid,
	input wire [3:0]  flow_cmd,
	input wire [3:0]  ex_dst_reg,
	input wire [1:0]  ex_dst_mode,
	input wire [3:0]  pf_src_reg,
	input wire [1:0]  pf_src_mode,
	input wire [15:0] stack_pointer_reg,
	// sequencer outputs
	input wire [22:0] prog_addr,
	input wire        stall,
	input wire        busy,
	input wire        stack_wr,
	input wire        stack_rd,
	input wire [15:0] stack_addr,
	input wire [15:0] stack_wr_data,
	input wire [15:0] stack_ptr_new,
	input wire        stack_ptr_upd
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire taken = instr_valid && !busy && !stall;
	sequence push_s;
		stack_wr && !$past(stack_wr) ##1 stack_wr && stack_addr == $past(stack_addr) + 16'h0002;
	endsequence
	sequence pop_s;
		stack_rd ##1 stack_rd;
	endsequence
	pc_even_a: assert property (prog_addr[0] == 1'b0) else $error("odd program address");
	stall_once_a: assert property (stall |=> !stall) else $error("stall longer than one cycle");
	call_push_a: assert property (taken && flow_cmd inside {`PFS_CMD_CALL, `PFS_CMD_CALL_W, `PFS_CMD_RELATIVE_CALL,
		`PFS_CMD_RELATIVE_CALL_W, `PFS_CMD_EXC} |-> ##2 push_s) else $error("push pair missing");
	push_base_a: assert property (stack_wr && !$past(stack_wr) |-> stack_addr == stack_pointer_reg)
		else $error("push not at stack pointer");
	push_high_a: assert property (stack_wr && $past(stack_wr) |-> stack_wr_data[15:7] == 9'h000)
		else $error("high push word too wide");
	ptr_step_a: assert property (push_s |-> stack_ptr_upd && stack_ptr_new == stack_pointer_reg + 16'h0004)
		else $error("stack pointer not advanced by four");
	ret_pop_a: assert property (taken && flow_cmd inside {`PFS_CMD_RETURN, `PFS_CMD_RETURN_WITH_LITERAL, `PFS_CMD_RETURN_FROM_INTERRUPT}
		|-> ##[1:2] pop_s) else $error("pop pair missing");
	pop_base_a: assert property (stack_rd && !$past(stack_rd) |-> stack_addr == stack_pointer_reg - 16'h0002)
		else $error("pop not pre-decremented");
	no_stack_a: assert property (taken && flow_cmd inside {`PFS_CMD_SEQ, `PFS_CMD_BRA, `PFS_CMD_BRA_C,
		`PFS_CMD_GOTO, `PFS_CMD_GOTO_W} |=> !stack_wr && !stack_rd) else $error("stack used");
	raw_stall_a: assert property (taken && ex_dst_mode == `PFS_AM_DIRECT && pf_src_mode[1]
		&& ex_dst_reg == pf_src_reg |=> stall) else $error("hazard not stalled");
	direct_src_a: assert property (taken && pf_src_mode == `PFS_AM_DIRECT |=> !stall)
		else $error("direct source stalled");
endmodule
bind pfs_flow_seq pfs_flow_assertions chk (.*);

// *** testbench/pfs_stack_model.sv ***
`timescale 1ns/1ns
module pfs_stack_model (
	// clock and reset
	input  wire        clk,
	input  wire        reset,
	// stack access
	input  wire        stack_wr,
	input  wire        stack_rd,
	input  wire [15:0] stack_addr,
	input  wire [15:0] stack_wr_data,
	input  wire [15:0] stack_ptr_new,
	input  wire        stack_ptr_upd,
	// answers
	output reg  [15:0] stack_pointer_reg,
	output reg  [15:0] stack_rd_data
);
	reg [15:0] mem_q [0:127];
	always @(posedge clk) begin
		if (reset) begin
			stack_pointer_reg <= 16'h0800;
			stack_rd_data <= 16'h0000;
		end else begin
			if (stack_ptr_upd)
				stack_pointer_reg <= stack_ptr_new;
			if (stack_wr)
				mem_q[stack_addr[7:1]] <= stack_wr_data;
			// read data lasts one cycle, then flips so a late sample is caught
			stack_rd_data <= stack_rd ? mem_q[stack_addr[7:1]] : ~stack_rd_data;
		end
	end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`include "pfs_regs.vh"
module testbench;
	reg         clk;
	reg         reset;
	reg         instr_valid;
	reg  [3:0]  flow_cmd;
	reg         cond_true;
	reg  [23:0] instr_word;
	reg  [22:0] absolute_target23;
	reg  [15:0] signed_disp16;
	reg  [15:0] working_reg_n;
	reg  [22:0] vector_addr;
	reg  [3:0]  imm_kind;
	reg  [3:0]  ex_dst_reg;
	reg  [1:0]  ex_dst_mode;
	reg  [3:0]  pf_src_reg;
	reg  [1:0]  pf_src_mode;
	reg         do_active;
	reg  [22:0] loop_start_address;
	reg  [22:0] loop_end_address;
	reg         repeat_active;
	wire [15:0] stack_pointer_reg;
	wire [15:0] stack_rd_data;
	wire [22:0] prog_addr;
	wire        stall;
	wire        busy;
	wire [15:0] imm_out;
	wire        stack_wr;
	wire        stack_rd;
	wire [15:0] stack_addr;
	wire [15:0] stack_wr_data;
	wire [15:0] stack_ptr_new;
	wire        stack_ptr_upd;
	integer     n_errors;
	integer     comparisons;
	integer     cycles;
	reg  [22:0] pc;
	reg  [22:0] stk [$];
	pfs_flow_seq dut (.*);
	pfs_stack_model stack_mem (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task close_out;
		begin
			$display("errors %0d, comparisons %0d", n_errors, comparisons);
			if (n_errors == 0 && comparisons > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	task check(input [22:0] seen, input [22:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	// one instruction, then wait out any stack traffic and the output delay
	task issue(input [3:0] c);
		integer i;
		begin
			@(posedge clk);
			instr_valid <= 1'b1;
			flow_cmd <= c;
			@(posedge clk);
			instr_valid <= 1'b0;
			#1;
			for (i = 0; i < 20 && busy !== 1'b0; i = i + 1)
				@(posedge clk) #1;
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	task flow(input [3:0] c);
		reg [22:0] ret;
		begin
			ret = pc + `PFS_PC_STEP;
			issue(c);
			case (c)
				`PFS_CMD_SEQ: pc = repeat_active ? pc : (do_active && pc == loop_end_address) ? loop_start_address : ret;
				`PFS_CMD_BRA: pc = pc + {{6{signed_disp16[15]}}, signed_disp16, 1'b0};
				`PFS_CMD_BRA_C: pc = cond_true ? pc + {{6{signed_disp16[15]}}, signed_disp16, 1'b0} : ret;
				`PFS_CMD_CALL: begin stk.push_back(pc + `PFS_PC_STEP2); pc = absolute_target23; end
				`PFS_CMD_CALL_W: begin stk.push_back(ret); pc = {7'h00, working_reg_n}; end
				`PFS_CMD_GOTO: pc = absolute_target23;
				`PFS_CMD_GOTO_W: pc = {7'h00, working_reg_n};
				`PFS_CMD_RELATIVE_CALL: begin stk.push_back(ret); pc = pc + {{6{signed_disp16[15]}}, signed_disp16, 1'b0}; end
				`PFS_CMD_RELATIVE_CALL_W: begin stk.push_back(ret); pc = pc + {6'h00, working_reg_n, 1'b0}; end
				`PFS_CMD_EXC: begin stk.push_back(ret); pc = vector_addr; end
				default: pc = stk.pop_back();
			endcase
			check(prog_addr, pc);
		end
	endtask
	task t_branch;
		begin
			flow(`PFS_CMD_SEQ);
			signed_disp16 <= 16'hFFFE;
			flow(`PFS_CMD_BRA);
			flow(`PFS_CMD_BRA_C);
			cond_true <= 1'b1;
			signed_disp16 <= 16'h0040;
			flow(`PFS_CMD_BRA_C);
		end
	endtask
	task t_calls;
		begin
			absolute_target23 <= 23'h012340;
			working_reg_n <= 16'h0456;
			vector_addr <= 23'h000200;
			flow(`PFS_CMD_CALL);
			flow(`PFS_CMD_CALL_W);
			flow(`PFS_CMD_RETURN_WITH_LITERAL);
			flow(`PFS_CMD_RETURN);
			flow(`PFS_CMD_RELATIVE_CALL);
			flow(`PFS_CMD_RELATIVE_CALL_W);
			flow(`PFS_CMD_RETURN);
			flow(`PFS_CMD_RETURN);
			flow(`PFS_CMD_GOTO);
			flow(`PFS_CMD_GOTO_W);
			flow(`PFS_CMD_EXC);
			flow(`PFS_CMD_RETURN_FROM_INTERRUPT);
		end
	endtask
	task t_loops;
		begin
			do_active <= 1'b1;
			loop_end_address <= pc;
			loop_start_address <= 23'h000100;
			flow(`PFS_CMD_SEQ);
			do_active <= 1'b0;
			repeat_active <= 1'b1;
			flow(`PFS_CMD_SEQ);
			repeat_active <= 1'b0;
		end
	endtask
	task t_imm;
		integer k;
		integer w;
		begin
			instr_word <= 24'hFFFFF0;
			for (k = 0; k < 11; k = k + 1) begin
				imm_kind <= k[3:0];
				w = k == 0 ? 1 : k < 4 ? 4 : k == 4 ? 5 : k == 5 ? 6 : k == 6 ? 8 : k < 9 ? 10 : k == 9 ? 14 : 16;
				repeat (2) @(posedge clk);
				#1;
				check(imm_out, (k == 3 || k == 5 || k == 8) ? 16'hFFFF : (17'h00001 << w) - 1'b1);
			end
		end
	endtask
	task t_hazard;
		begin
			ex_dst_reg <= 4'h5;
			ex_dst_mode <= `PFS_AM_DIRECT;
			pf_src_reg <= 4'h5;
			pf_src_mode <= `PFS_AM_IND;
			@(posedge clk);
			instr_valid <= 1'b1;
			flow_cmd <= `PFS_CMD_SEQ;
			@(posedge clk) #1;
			check(stall, 1'b1);
			@(posedge clk) #1;
			check(stall, 1'b0);
			instr_valid <= 1'b0;
			ex_dst_mode <= `PFS_AM_NONE;
			pf_src_reg <= `PFS_SP_REG;
			issue(`PFS_CMD_CALL);
			@(posedge clk);
			instr_valid <= 1'b1;
			@(posedge clk) #1;
			check(stall, 1'b1);
		end
	endtask
	initial begin
		{reset, instr_valid, flow_cmd, cond_true, instr_word, absolute_target23, signed_disp16, working_reg_n,
			vector_addr, imm_kind, ex_dst_reg, ex_dst_mode, pf_src_reg, do_active, loop_start_address,
			loop_end_address, repeat_active} = '0;
		pf_src_mode = `PFS_AM_DIRECT;
		reset = 1'b1;
		pc = 23'h000000;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		#1;
		check(prog_addr, `PFS_PC_RESET);
		t_branch;
		t_calls;
		t_loops;
		t_imm;
		t_hazard;
		close_out;
	end
endmodule
